/* sequence_parameter_stepper_test.sv */
module sequence_parameter_stepper_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_sys_clk;
  logic i_rst_n;
  logic [7:0] i_addr;
  logic [31:0] i_wr_data;
  logic i_wr_en;
  logic i_rd_en;
  logic [31:0] o_rd_data;
  logic i_integ_start;
  logic [1:0] i_input_lines;
  logic [4:0] o_seq_index;
  logic o_seq_active;
  logic o_setup_preview;
  logic o_capturing;
  logic [63:0] notes[$];
  logic rd_seen;
  logic [63:0] nt;
  logic [7:0] st_notes[$];
  logic st_req;
  int err_total;
  int check_count;
  int cyc;

  sps_stepper sps_stepper_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data),
    .i_integ_start(i_integ_start),
    .i_input_lines(i_input_lines),
    .o_seq_index(o_seq_index),
    .o_seq_active(o_seq_active),
    .o_setup_preview(o_setup_preview),
    .o_capturing(o_capturing)
  );

  sps_host_lines sps_host_lines_inst (
    .i_sys_clk(i_sys_clk),
    .o_integ_start(i_integ_start),
    .o_lines(i_input_lines)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m))
    begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp & m, got & m);
    end
  endtask : chk_rd

  task automatic chk_st(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_st

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  // Notes the expectation; the monitor compares when the data appear
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    notes.push_back({m, e});
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
  endtask : rd

  // Notes the expected status outputs {preview, active, capturing, index}
  task automatic st(input logic [7:0] e);
    @(posedge i_sys_clk);
    st_req <= 1'b1;
    st_notes.push_back(e);
    @(posedge i_sys_clk);
    st_req <= 1'b0;
  endtask : st

  ////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge i_sys_clk)
  begin
    if (rd_seen)
    begin
      if (notes.size() == 0)
        chk_rd(32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      else
      begin
        nt = notes.pop_front();
        chk_rd(nt[31:0], o_rd_data, nt[63:32]);
      end
    end
    if (st_req)
    begin
      if (st_notes.size() == 0)
        chk_st(8'h00, 8'hFF);
      else
        chk_st(st_notes.pop_front(), {o_setup_preview, o_seq_active, o_capturing, o_seq_index});
    end
    rd_seen <= i_rd_en;
  end

  // Guards against a hang; the whole run needs well under this
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;
  localparam logic [31:0] PTR = 32'h0001_001F;

  initial
  begin
    logic [7:0] src[4];
    logic [7:0] rpt[4];
    logic [7:0] ua;
    src = '{8'h80, 8'h84, 8'h82, 8'h55};
    rpt = '{8'h02, 8'h00, 8'h01, 8'h01};
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wr_data = 32'h0;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    rd_seen = 1'b0;
    st_req = 1'b0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    void'($urandom(22));
    rd(sps_pkg::OFS_CTRL, 32'h0020_2000, FULL);
    st(8'h00);
    // Any unmapped address is ignored on write and reads back as zero
    ua = 8'h18 + 8'($urandom_range(0, 231));
    wr(ua, $urandom());
    rd(ua, 32'h0, FULL);
    // Program with preview on, clear it before real use
    wr(sps_pkg::OFS_CTRL, 32'h0000_0402);
    for (int i = 0; i < 4; i++)
    begin
      wr(sps_pkg::OFS_ENTRY_SEL, 32'(i));
      wr(sps_pkg::OFS_ENTRY, {8'h00, rpt[i], src[i], 8'h00});
    end
    st(8'h83);
    rd(sps_pkg::OFS_ENTRY_SEL, 32'h3, FULL);
    rd(sps_pkg::OFS_ENTRY, 32'h0001_5500, FULL);
    wr(sps_pkg::OFS_CTRL, 32'h0000_0401);
    rd(sps_pkg::OFS_CTRL, 32'h0020_0401, FULL);
    wr(sps_pkg::OFS_LINE_CTRL, 32'h9);
    rd(sps_pkg::OFS_LINE_CTRL, 32'h9, FULL);
    wr(sps_pkg::OFS_CAPTURE, 32'h2);
    rd(sps_pkg::OFS_CAPTURE, 32'h10, 32'h18);
    repeat ($urandom_range(1, 4)) @(posedge i_sys_clk);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0100, FULL);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0001, FULL);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0001, FULL);
    sps_host_lines_inst.set_lines(2'b01);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0002, FULL);
    st(8'h62);
    sps_host_lines_inst.set_lines(2'b00);
    sps_host_lines_inst.set_lines(2'b01);
    rd(sps_pkg::OFS_STEP, 32'h0001_0003, FULL);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0003, FULL);
    sps_host_lines_inst.set_lines(2'b11);
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, PTR);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0100, FULL);
    wr(sps_pkg::OFS_STEP, 32'h1);
    rd(sps_pkg::OFS_STEP, 32'h0001_0001, FULL);
    wr(sps_pkg::OFS_STEP, 32'h2);
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, PTR);
    // Both lines as step inputs: only the AND of them counts
    wr(sps_pkg::OFS_LINE_CTRL, 32'h5);
    sps_host_lines_inst.set_lines(2'b01);
    repeat (2) wr(sps_pkg::OFS_STEP, 32'h1);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0001, FULL);
    sps_host_lines_inst.set_lines(2'b11);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0002, FULL);
    wr(sps_pkg::OFS_CAPTURE, 32'h4);
    wr(sps_pkg::OFS_CAPTURE, 32'h2);
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, PTR);
    // Single frame: every capture starts over at the first entry
    wr(sps_pkg::OFS_CAPTURE, 32'h9);
    repeat (2) wr(sps_pkg::OFS_STEP, 32'h1);
    rd(sps_pkg::OFS_STEP, 32'h0001_0001, PTR);
    sps_host_lines_inst.image();
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, PTR);
    // Storage goes stale on disable until the host reloads an entry
    wr(sps_pkg::OFS_CTRL, 32'h0000_0400);
    wr(sps_pkg::OFS_CTRL, 32'h0000_0401);
    rd(sps_pkg::OFS_STEP, 32'h0, 32'h0001_0000);
    st(8'h20);
    wr(sps_pkg::OFS_STEP, 32'h1);
    rd(sps_pkg::OFS_STEP, 32'h0, PTR);
    wr(sps_pkg::OFS_ENTRY, {8'h00, rpt[3], src[3], 8'h00});
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, 32'h0001_0000);
    // Wrap flag is set while capture is stopped; the final entry then wraps to the first
    wr(sps_pkg::OFS_CAPTURE, 32'h4);
    st(8'h40);
    wr(sps_pkg::OFS_CTRL, 32'h0000_0405);
    wr(sps_pkg::OFS_CAPTURE, 32'h2);
    repeat (4) wr(sps_pkg::OFS_STEP, 32'h1);
    rd(sps_pkg::OFS_STEP, 32'h0001_0003, PTR);
    wr(sps_pkg::OFS_STEP, 32'h1);
    rd(sps_pkg::OFS_STEP, 32'h0001_0000, PTR);
    st(8'h60);
    // Reset again in mid-run: everything returns to its reset value
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    st(8'h00);
    rd(sps_pkg::OFS_CTRL, 32'h0020_2000, FULL);
    repeat (4) @(posedge i_sys_clk);
    conclude();
  end

endmodule : sequence_parameter_stepper_test

/* sps_host_lines.sv */
module sps_host_lines (
  input wire logic i_sys_clk,
  output logic o_integ_start,
  output logic [1:0] o_lines
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_integ_start = 1'b0;
    o_lines = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One image start pulse, one cycle long
  task automatic image();
    @(posedge i_sys_clk);
    o_integ_start <= 1'b1;
    @(posedge i_sys_clk);
    o_integ_start <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask : image

  // Line levels move with no regard to image timing, then settle past the sync
  task automatic set_lines(input logic [1:0] v);
    @(posedge i_sys_clk);
    o_lines <= v;
    repeat (6) @(posedge i_sys_clk);
  endtask : set_lines

endmodule : sps_host_lines

/* sps_line_sync.sv */
module sps_line_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_lines,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sps_sync_t;

  sps_sync_t s_q;
  sps_sync_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops before use; only the second stage feeds the edge detector

  always_comb
  begin
    s_d = s_q;
    s_d.meta = i_lines;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.sync;
  assign o_rise = s_q.sync & ~s_q.prev;

endmodule : sps_line_sync

/* sps_pkg.sv */
package sps_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENTRY_SEL = 8'h04;
  localparam logic [7:0] OFS_ENTRY = 8'h08;
  localparam logic [7:0] OFS_STEP = 8'h0C;
  localparam logic [7:0] OFS_LINE_CTRL = 8'h10;
  localparam logic [7:0] OFS_CAPTURE = 8'h14;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SETUP_BIT = 1;
  localparam int CTRL_WRAP_BIT = 2;
  localparam int CTRL_COUNT_LSB = 8;
  localparam int CTRL_MAXLEN_LSB = 16;

  // Entry register fields
  localparam int ENTRY_SRC_LSB = 8;
  localparam int ENTRY_RPT_LSB = 16;

  // Step register fields
  localparam int STEP_ADV_BIT = 0;
  localparam int STEP_REW_BIT = 1;
  localparam int STEP_REP_LSB = 8;
  localparam int STEP_ACTIVE_BIT = 16;

  // Capture register fields
  localparam int CAP_BURST_BIT = 0;
  localparam int CAP_STREAM_BIT = 1;
  localparam int CAP_STOP_BIT = 2;
  localparam int CAP_ONE_FRAME_BIT = 3;
  localparam int CAP_RUNNING_BIT = 4;

  // Input line roles, two bits per line
  localparam logic [1:0] LINE_OFF = 2'h0;
  localparam logic [1:0] LINE_STEP = 2'h1;
  localparam logic [1:0] LINE_REWIND = 2'h2;

  // Step source codes
  localparam logic [7:0] SRC_INTEG = 8'h80;
  localparam logic [7:0] SRC_EDGE = 8'h82;
  localparam logic [7:0] SRC_LEVEL = 8'h84;

  // Sizes and reset values
  localparam int SEQ_DEPTH = 32;
  localparam int LINE_COUNT = 2;
  localparam logic [7:0] RST_SET_COUNT = 8'h20;

endpackage : sps_pkg

/* sps_stepper.sv */
// Summary of operation
// - Each entry is applied to n consecutive images, n its repeat count.
// - Each of two input lines can be a step input or a rewind input.
// - Two lines both set as step inputs are ANDed into one condition.
// - Level stepping advances at every image while the step input is high.
// - Level changes are accepted any time, not aligned to images.
// - Edge stepping advances exactly one entry per rising edge, at once.
// - Step source is stored separately for every entry.
// - The rewind input is always edge sensitive.
// - A rewind input rising edge returns the pointer to the first entry.
// - Software commands step and rewind like the input lines.
// - Images beyond the programmed length keep the final entry, or wrap to the first when the wrap bit is set.
// - Disabling sequencing invalidates storage; host reloads before re-enabling.
// - Burst or streaming start command rewinds the sequence.
// - Single-frame capture rewinds the sequence on every capture.
// - Source 80 integration, 82 rising edge, 84 high level, others as 80.
// - Repeat count zero acts as one.
// - Each manual advance write steps once, honouring the repeat count.
// - Storage holds 32 complete entries.
//
// Chosen here: strobed register access and the register addresses.
module sps_stepper #(
  parameter int DEPTH = sps_pkg::SEQ_DEPTH,
  parameter int LINES = sps_pkg::LINE_COUNT
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic i_integ_start,
  input wire logic [LINES-1:0] i_input_lines,
  output logic [$clog2(DEPTH)-1:0] o_seq_index,
  output logic o_seq_active,
  output logic o_setup_preview,
  output logic o_capturing
);

  localparam int IW = $clog2(DEPTH);

  typedef struct packed {
    logic [31:0] rd_data;
    logic enable;
    logic setup;
    logic wrap;
    logic [7:0] set_count;
    logic [IW-1:0] sel;
    logic [2*LINES-1:0] line_ctrl;
    logic [IW-1:0] ptr;
    logic [7:0] rep;
    logic capturing;
    logic one_frame;
    logic valid;
    logic step_prev;
    logic [IW-1:0] index_out;
    logic active_out;
    logic [DEPTH-1:0][7:0] src;
    logic [DEPTH-1:0][7:0] rpt;
  } sps_state_t;

  sps_state_t s_q;
  sps_state_t s_d;

  logic [LINES-1:0] line_lvl;
  logic [LINES-1:0] line_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] eff_source(input logic [7:0] code);
    if (code == sps_pkg::SRC_EDGE || code == sps_pkg::SRC_LEVEL)
    begin
      return code;
    end
    return sps_pkg::SRC_INTEG;
  endfunction : eff_source

  function automatic logic [7:0] eff_repeat(input logic [7:0] cnt);
    return (cnt == 8'h00) ? 8'h01 : cnt;
  endfunction : eff_repeat

  function automatic logic [IW-1:0] last_index(input logic [7:0] cnt);
    if (cnt == 8'h00)
    begin
      return '0;
    end
    if (32'(cnt) > DEPTH)
    begin
      return IW'(DEPTH - 1);
    end
    return IW'(cnt - 8'h01);
  endfunction : last_index

  function automatic logic [IW-1:0] next_index(input logic [IW-1:0] cur,
                                               input logic [7:0] cnt,
                                               input logic wrap);
    if (cur >= last_index(cnt))
    begin
      return wrap ? '0 : cur;
    end
    return IW'(cur + 1'b1);
  endfunction : next_index

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser

  sps_line_sync #(
    .WIDTH(LINES)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_lines(i_input_lines),
    .o_level(line_lvl),
    .o_rise(line_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [LINES-1:0] step_mask;
  logic [LINES-1:0] rew_mask;
  logic step_lvl;
  logic step_rise;
  logic rew_rise;
  logic wr_ctrl;
  logic wr_step;
  logic wr_cap;
  logic cap_cmd;
  logic rewind;
  logic active;
  logic img_step;
  logic [7:0] cur_src;
  logic cnt_evt;
  logic edge_adv;

  always_comb
  begin
    for (int i = 0; i < LINES; i++)
    begin
      step_mask[i] = (s_q.line_ctrl[2*i +: 2] == sps_pkg::LINE_STEP);
      rew_mask[i] = (s_q.line_ctrl[2*i +: 2] == sps_pkg::LINE_REWIND);
    end
  end

  // Unused step lines count as high so the AND sees only the step lines
  assign step_lvl = (step_mask != '0) && (&(line_lvl | ~step_mask));
  assign step_rise = step_lvl & ~s_q.step_prev;
  assign rew_rise = |(line_rise & rew_mask);

  assign wr_ctrl = i_wr_en && (i_addr == sps_pkg::OFS_CTRL);
  assign wr_step = i_wr_en && (i_addr == sps_pkg::OFS_STEP);
  assign wr_cap = i_wr_en && (i_addr == sps_pkg::OFS_CAPTURE);
  assign cap_cmd = wr_cap && (i_wr_data[sps_pkg::CAP_BURST_BIT] ||
                              i_wr_data[sps_pkg::CAP_STREAM_BIT]);
  assign active = s_q.enable && s_q.valid;
  assign img_step = i_integ_start && s_q.capturing && !s_q.one_frame;
  assign cur_src = eff_source(s_q.src[s_q.ptr]);

  always_comb
  begin
    cnt_evt = wr_step && i_wr_data[sps_pkg::STEP_ADV_BIT];
    edge_adv = 1'b0;
    unique case (cur_src)
      sps_pkg::SRC_EDGE:
      begin
        edge_adv = step_rise;
      end
      sps_pkg::SRC_LEVEL:
      begin
        // Level is sampled at the image, wherever it changed before
        cnt_evt = cnt_evt || (img_step && step_lvl);
      end
      default:
      begin
        cnt_evt = cnt_evt || img_step;
      end
    endcase
  end

  assign rewind = rew_rise || cap_cmd ||
                  (wr_step && i_wr_data[sps_pkg::STEP_REW_BIT]) ||
                  (i_integ_start && s_q.one_frame);

  always_comb
  begin
    s_d = s_q;
    s_d.rd_data = '0;
    s_d.step_prev = step_lvl;

    // Register writes
    if (wr_ctrl)
    begin
      s_d.enable = i_wr_data[sps_pkg::CTRL_ENABLE_BIT];
      s_d.setup = i_wr_data[sps_pkg::CTRL_SETUP_BIT];
      s_d.wrap = i_wr_data[sps_pkg::CTRL_WRAP_BIT];
      s_d.set_count = i_wr_data[sps_pkg::CTRL_COUNT_LSB +: 8];
    end
    if (i_wr_en && i_addr == sps_pkg::OFS_ENTRY_SEL)
    begin
      s_d.sel = i_wr_data[IW-1:0];
    end
    if (i_wr_en && i_addr == sps_pkg::OFS_LINE_CTRL)
    begin
      s_d.line_ctrl = i_wr_data[2*LINES-1:0];
    end
    if (wr_cap)
    begin
      s_d.one_frame = i_wr_data[sps_pkg::CAP_ONE_FRAME_BIT];
      if (i_wr_data[sps_pkg::CAP_STOP_BIT])
      begin
        s_d.capturing = 1'b0;
      end
      if (cap_cmd)
      begin
        s_d.capturing = 1'b1;
      end
    end

    // Storage goes stale when sequencing is switched off; an entry write
    // in the same cycle still counts as a reload
    if (s_q.enable && !s_d.enable)
    begin
      s_d.valid = 1'b0;
    end
    if (i_wr_en && i_addr == sps_pkg::OFS_ENTRY)
    begin
      s_d.src[s_q.sel] = i_wr_data[sps_pkg::ENTRY_SRC_LSB +: 8];
      s_d.rpt[s_q.sel] = i_wr_data[sps_pkg::ENTRY_RPT_LSB +: 8];
      s_d.valid = 1'b1;
    end

    // Pointer: rewind beats any step arriving in the same cycle
    if (rewind)
    begin
      s_d.ptr = '0;
      s_d.rep = '0;
    end
    else if (active && (edge_adv ||
             (cnt_evt && (8'(s_q.rep + 8'h01) >= eff_repeat(s_q.rpt[s_q.ptr])))))
    begin
      s_d.ptr = next_index(s_q.ptr, s_q.set_count, s_q.wrap);
      s_d.rep = '0;
    end
    else if (active && cnt_evt)
    begin
      s_d.rep = 8'(s_q.rep + 8'h01);
    end

    // Read data, one cycle after the strobe
    if (i_rd_en)
    begin
      unique case (i_addr)
        sps_pkg::OFS_CTRL:
        begin
          s_d.rd_data[sps_pkg::CTRL_ENABLE_BIT] = s_q.enable;
          s_d.rd_data[sps_pkg::CTRL_SETUP_BIT] = s_q.setup;
          s_d.rd_data[sps_pkg::CTRL_WRAP_BIT] = s_q.wrap;
          s_d.rd_data[sps_pkg::CTRL_COUNT_LSB +: 8] = s_q.set_count;
          s_d.rd_data[sps_pkg::CTRL_MAXLEN_LSB +: 8] = 8'(DEPTH);
        end
        sps_pkg::OFS_ENTRY_SEL:
        begin
          s_d.rd_data[IW-1:0] = s_q.sel;
        end
        sps_pkg::OFS_ENTRY:
        begin
          s_d.rd_data[sps_pkg::ENTRY_SRC_LSB +: 8] = s_q.src[s_q.sel];
          s_d.rd_data[sps_pkg::ENTRY_RPT_LSB +: 8] = s_q.rpt[s_q.sel];
        end
        sps_pkg::OFS_STEP:
        begin
          s_d.rd_data[IW-1:0] = s_q.ptr;
          s_d.rd_data[sps_pkg::STEP_REP_LSB +: 8] = s_q.rep;
          s_d.rd_data[sps_pkg::STEP_ACTIVE_BIT] = active;
        end
        sps_pkg::OFS_LINE_CTRL:
        begin
          s_d.rd_data[2*LINES-1:0] = s_q.line_ctrl;
        end
        sps_pkg::OFS_CAPTURE:
        begin
          s_d.rd_data[sps_pkg::CAP_ONE_FRAME_BIT] = s_q.one_frame;
          s_d.rd_data[sps_pkg::CAP_RUNNING_BIT] = s_q.capturing;
        end
        default:
        begin
          s_d.rd_data = '0;
        end
      endcase
    end

    // Preview shows the entry being edited so its effect is visible
    s_d.index_out = s_d.setup ? s_d.sel : s_d.ptr;
    s_d.active_out = s_d.enable && s_d.valid;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
      s_q.set_count <= sps_pkg::RST_SET_COUNT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rd_data = s_q.rd_data;
  assign o_seq_index = s_q.index_out;
  assign o_seq_active = s_q.active_out;
  assign o_setup_preview = s_q.setup;
  assign o_capturing = s_q.capturing;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_line_rewind;
    rew_rise;
  endsequence
  sequence s_ptr_first;
    s_q.ptr == '0 && s_q.rep == 8'h00;
  endsequence
  sequence s_edge_step;
    active && cur_src == sps_pkg::SRC_EDGE && step_rise && !rewind &&
    s_q.ptr < last_index(s_q.set_count);
  endsequence

  a_line_rewind: assert property (s_line_rewind |=> s_ptr_first)
    else $error("rewind line edge did not return pointer to first entry");
  a_start_rewind: assert property (cap_cmd |=> s_ptr_first)
    else $error("capture start did not rewind sequence");
  a_single_frame: assert property (i_integ_start && s_q.one_frame |=> s_ptr_first)
    else $error("single frame capture did not rewind sequence");
  a_edge_step: assert property (s_edge_step |=> s_q.ptr == IW'($past(s_q.ptr) + 1'b1))
    else $error("edge did not advance exactly one entry");
  a_last_hold: assert property (!rewind && !s_q.wrap &&
      s_q.ptr == last_index(s_q.set_count) |=> s_q.ptr == $past(s_q.ptr))
    else $error("pointer moved past the final entry");
  a_zero_repeat: assert property (active && !rewind && cnt_evt &&
      s_q.rpt[s_q.ptr] == 8'h00 && s_q.ptr < last_index(s_q.set_count)
      |=> s_q.ptr != $past(s_q.ptr) && s_q.rep == 8'h00)
    else $error("repeat count zero did not act as one");
  a_repeat_hold: assert property (active && !rewind && !edge_adv && cnt_evt &&
      8'(s_q.rep + 8'h01) < eff_repeat(s_q.rpt[s_q.ptr])
      |=> $stable(s_q.ptr) && s_q.rep == 8'($past(s_q.rep) + 8'h01))
    else $error("entry left before its repeat count");
  a_and_gate: assert property (step_mask == '1 && line_lvl != '1 |-> !step_lvl)
    else $error("step lines not ANDed");
  a_level_idle: assert property (active && !rewind && cur_src == sps_pkg::SRC_LEVEL &&
      !step_lvl && !wr_step |=> $stable(s_q.ptr) [*1])
    else $error("level stepping moved with low step input");
  a_read_ctrl: assert property (i_rd_en && i_addr == sps_pkg::OFS_CTRL
      |=> o_rd_data[sps_pkg::CTRL_ENABLE_BIT] == $past(s_q.enable) &&
      o_rd_data[sps_pkg::CTRL_MAXLEN_LSB +: 8] == 8'(DEPTH)
      ##1 (o_rd_data == '0 || $past(i_rd_en)))
    else $error("control read data not valid one cycle after strobe");

endmodule : sps_stepper
